//--- inc/sss_defines.svh
/*
 * Constants of the full-duplex synchronous serial block: register word
 * indices, field positions, reset values and serial clock timing.
 * Assumes a 32-bit classic Wishbone bus and a 250 MHz system clock.
 */
// Overview of operation
// R01: Software picks duplex mode, fills the buffer, then sets the start bit.
// R02: Each outgoing bit is driven on the leading serial clock edge.
// R03: Each incoming bit is sampled on the trailing serial clock edge.
// R04: A complete received byte moves from the shifter into its buffer word.
// R05: Completion interrupt fires after the programmed number of words.
// R06: Software reads all received words before writing new outgoing words.
// R07: Internal clock pauses until serviced; one written word prevents the pause.
// R08: With external clock software services the buffer before the next shift.
// R09: Software ends the exchange by clearing start or setting inhibit.
// R10: Clearing start stores the current word and stops after its last bit.
// R11: The active flag drops to zero when the exchange has finished.
// R12: Setting inhibit ends the exchange at once and clears the active flag.
// R13: External clock: clear start, wait for idle, then change the word count.
// R14: Internal clock: count may change in the pause before buffer access.
// R15: A mode change discards buffer contents; finish and read first.
// R16: Word count field allows one to eight words per transfer.
// R17: Words shift least significant bit first in both directions.
// R18: Leading edge is the falling edge, trailing edge the rising edge.
// R19: During the automatic pause the serial clock is held stopped.
// R20: The active flag sets when start is written and holds until termination.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

// Register word indices (byte address is four times the index)
`define SSS_IDX_CTRL1 4'h0
`define SSS_IDX_CTRL2 4'h1
`define SSS_IDX_STAT 4'h2
// Buffer words sit where this address bit is set, index in bits 4..2
`define SSS_BUF_BIT 5

// Control one fields
`define SSS_C1_START 0
`define SSS_C1_INH 1
`define SSS_C1_MODE 2
`define SSS_C1_EXT 4
`define SSS_MODE_DUPLEX 2'h3
`define SSS_CTRL1_RST 5'h00

// Control two: word count minus one in bits 2..0
`define SSS_C2_CNT 0
`define SSS_CTRL2_RST 3'h0

// Status fields
`define SSS_ST_ACTIVE 0
`define SSS_ST_WAIT 1

// Serial clock timing
`define SSS_CLK_NS 4
`define SSS_SCK_HALF_NS 16
`define SSS_SCK_HALF_CYC ((`SSS_SCK_HALF_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)

`endif

//--- inc/sss_pkg.sv
/*
 * Types of the full-duplex synchronous serial block.
 * Assumes sss_defines.svh for all numeric constants.
 */
package sss_pkg;

	// Control one as held by the block
	typedef struct packed {
		logic ext_clk;
		logic [1:0] mode;
		logic inhibit;
		logic start;
	} sss_ctrl_t;

	// Transfer sequencer, Gray coded along idle, run, pause
	typedef enum logic [1:0] {
		SSS_IDLE = 2'h0,
		SSS_RUN = 2'h1,
		SSS_WAIT = 2'h3
	} sss_state_t;

endpackage

//--- verilog/sss_shift.sv
/*
 * Byte shifter: drives on falling serial edges, samples on rising ones.
 * Assumes edge pulses and serial input already synchronised to clk_i.
 */
`timescale 1ns/10ps
module sss_shift (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic load_i,
	input wire logic [7:0] word_i,
	input wire logic fall_i,
	input wire logic rise_i,
	input wire logic si_i,
	// Results
	output logic so_o,
	output logic done_o,
	output logic [7:0] rx_word_o
);
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	logic [2:0] cnt;

	// Last rising edge of a byte completes it
	assign done_o = rise_i && (cnt == 3'h7);
	assign rx_word_o = {si_i, rx_sh[7:1]};

	// Transmit side, least significant bit first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_sh <= 8'h00;
			so_o <= 1'b1;
		end else if (ce_i) begin
			if (load_i) begin
				tx_sh <= word_i;
			end else if (fall_i) begin
				so_o <= tx_sh[0]; // R02 R17 R18
				tx_sh <= {1'b0, tx_sh[7:1]};
			end
		end
	end

	// Receive side fills from the top so bit 0 arrives first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_sh <= 8'h00;
			cnt <= 3'h0;
		end else if (ce_i) begin
			if (load_i) begin
				cnt <= 3'h0;
			end else if (rise_i) begin
				rx_sh <= {si_i, rx_sh[7:1]}; // R03 R17
				cnt <= cnt + 3'h1;
			end
		end
	end

	chk_tx_on_fall: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		!$stable(so_o) |-> $past(fall_i)) else $error("serial output moved off a falling edge");
	chk_rx_on_rise: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		rise_i && ce_i && !load_i |=> rx_sh[7] == $past(si_i)) else $error("input bit not sampled on rising edge");
endmodule

//--- verilog/sss_top.sv
/*
 * Full-duplex 8-bit synchronous serial block with a Wishbone register file.
 * Assumes a classic Wishbone master on clk_i and a serial partner whose
 * clock, when external, is slow enough to be sampled by clk_i.
 */
`timescale 1ns/10ps
`include "sss_defines.svh"
module sss_top #(
	parameter int HALF_CYC = `SSS_SCK_HALF_CYC,
	parameter int WORDS = 8
) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial link
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic si_i,
	output logic so_o,
	// Events and status
	output logic serial_done_irq_o,
	output logic transfer_active_flag_o
);
	sss_pkg::sss_ctrl_t ctrl;
	sss_pkg::sss_state_t state;
	logic [2:0] word_count;
	logic [7:0] shared_buffer_regs [WORDS];
	logic [2:0] word_idx;
	logic svc;
	logic [7:0] div;
	logic sck_int;
	logic ck_s1, ck_s2, ck_s3;
	logic si_s1, si_s2;
	logic wb_req, wr_ok;
	logic wr_c1, wr_c2, wr_buf;
	logic start_go, inhibit_go, mode_chg;
	logic fall, rise, word_done, last_word, resume, load;
	logic [2:0] load_idx;
	logic [7:0] rx_word;
	logic [7:0] load_word;
	logic [31:0] next_dat;

	// Word index of a bus address
	function automatic logic [3:0] reg_idx(input logic [5:0] adr);
		reg_idx = adr[5:2];
	endfunction

	// True when the address falls inside the buffer window
	function automatic logic is_buf(input logic [5:0] adr);
		is_buf = adr[`SSS_BUF_BIT];
	endfunction

	// Bus decode; only byte lane 0 carries register data
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ok = wb_req && wb_we_i && wb_sel_i[0];
	assign wr_c1 = wr_ok && !is_buf(wb_adr_i) && (reg_idx(wb_adr_i) == `SSS_IDX_CTRL1);
	assign wr_c2 = wr_ok && !is_buf(wb_adr_i) && (reg_idx(wb_adr_i) == `SSS_IDX_CTRL2);
	assign wr_buf = wr_ok && is_buf(wb_adr_i);

	// Start is only taken from idle, in duplex mode and without inhibit
	assign start_go = wr_c1 && wb_dat_i[`SSS_C1_START] && !wb_dat_i[`SSS_C1_INH]
		&& (wb_dat_i[`SSS_C1_MODE+1:`SSS_C1_MODE] == `SSS_MODE_DUPLEX)
		&& (state == sss_pkg::SSS_IDLE);
	assign inhibit_go = wr_c1 && wb_dat_i[`SSS_C1_INH];
	assign mode_chg = wr_c1 && (wb_dat_i[`SSS_C1_MODE+1:`SSS_C1_MODE] != ctrl.mode);

	// Serial edges come from the divider or from the synchronised pin
	always_comb begin
		fall = 1'b0;
		rise = 1'b0;
		if (state == sss_pkg::SSS_RUN) begin
			if (ctrl.ext_clk) begin
				fall = ck_s3 && !ck_s2;
				rise = !ck_s3 && ck_s2;
			end else if (div == 8'(HALF_CYC - 1)) begin
				fall = sck_int; // R18
				rise = !sck_int; // R18
			end
		end
	end

	assign last_word = (word_idx == word_count); // R16
	// A write seen in the completing cycle still counts as service
	assign resume = svc || wr_buf; // R07
	assign load = start_go || (word_done && ctrl.start && !inhibit_go
		&& (!last_word || ctrl.ext_clk || resume))
		|| ((state == sss_pkg::SSS_WAIT) && ctrl.start && resume && !inhibit_go);
	assign load_idx = (start_go || last_word || state == sss_pkg::SSS_WAIT) ? 3'h0 : word_idx + 3'h1;
	// A buffer write landing with the load is forwarded, else the stale byte would go out
	assign load_word = (wr_buf && (wb_adr_i[4:2] == load_idx)) ? wb_dat_i[7:0] : shared_buffer_regs[load_idx];

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_s1 <= 1'b1;
			ck_s2 <= 1'b1;
			ck_s3 <= 1'b1;
			si_s1 <= 1'b0;
			si_s2 <= 1'b0;
		end else if (ce_i) begin
			ck_s1 <= sck_i;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			si_s1 <= si_i;
			si_s2 <= si_s1;
		end
	end

	sss_shift u_shift (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.load_i(load),
		.word_i(load_word),
		.fall_i(fall),
		.rise_i(rise),
		.si_i(si_s2),
		.so_o(so_o),
		.done_o(word_done),
		.rx_word_o(rx_word)
	);

	// Control registers; inhibit also drops start so it cannot linger
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `SSS_CTRL1_RST;
			word_count <= `SSS_CTRL2_RST;
		end else if (ce_i) begin
			if (wr_c1) begin
				ctrl.start <= wb_dat_i[`SSS_C1_START] && !wb_dat_i[`SSS_C1_INH]; // R09
				ctrl.inhibit <= wb_dat_i[`SSS_C1_INH];
				ctrl.mode <= wb_dat_i[`SSS_C1_MODE+1:`SSS_C1_MODE];
				ctrl.ext_clk <= wb_dat_i[`SSS_C1_EXT];
			end
			if (wr_c2) begin
				word_count <= wb_dat_i[`SSS_C2_CNT+2:`SSS_C2_CNT]; // R16
			end
		end
	end

	// Shared buffer: received bytes win over a bus write to the same word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < WORDS; i++) begin
				shared_buffer_regs[i] <= 8'h00;
			end
		end else if (ce_i) begin
			if (mode_chg) begin
				for (int i = 0; i < WORDS; i++) begin
					shared_buffer_regs[i] <= 8'h00; // R15
				end
			end else begin
				if (wr_buf) begin
					shared_buffer_regs[wb_adr_i[4:2]] <= wb_dat_i[7:0];
				end
				if (word_done && !inhibit_go) begin
					shared_buffer_regs[word_idx] <= rx_word; // R04 R10
				end
			end
		end
	end

	// Transfer sequencer and active flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= sss_pkg::SSS_IDLE;
			word_idx <= 3'h0;
			transfer_active_flag_o <= 1'b0;
			serial_done_irq_o <= 1'b0;
		end else if (ce_i) begin
			serial_done_irq_o <= 1'b0;
			if (inhibit_go) begin
				state <= sss_pkg::SSS_IDLE; // R12
				transfer_active_flag_o <= 1'b0; // R12
				word_idx <= 3'h0;
			end else begin
				case (state)
					sss_pkg::SSS_IDLE: begin
						if (start_go) begin
							state <= sss_pkg::SSS_RUN;
							word_idx <= 3'h0;
							transfer_active_flag_o <= 1'b1; // R20
						end
					end
					sss_pkg::SSS_RUN: begin
						if (word_done) begin
							if (last_word) begin
								serial_done_irq_o <= 1'b1; // R05
							end
							if (!ctrl.start) begin
								state <= sss_pkg::SSS_IDLE; // R10
								transfer_active_flag_o <= 1'b0; // R11
								word_idx <= 3'h0;
							end else if (last_word) begin
								word_idx <= 3'h0;
								if (!ctrl.ext_clk && !resume) begin
									state <= sss_pkg::SSS_WAIT; // R07
								end
							end else begin
								word_idx <= word_idx + 3'h1;
							end
						end
					end
					sss_pkg::SSS_WAIT: begin
						if (!ctrl.start) begin
							state <= sss_pkg::SSS_IDLE; // R09
							transfer_active_flag_o <= 1'b0; // R11
						end else if (resume) begin
							state <= sss_pkg::SSS_RUN; // R07
						end
					end
					default: begin
						state <= sss_pkg::SSS_IDLE;
						transfer_active_flag_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Service flag: the clear at batch completion wins over a set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			svc <= 1'b0;
		end else if (ce_i) begin
			if (state == sss_pkg::SSS_IDLE || inhibit_go) begin
				svc <= 1'b0;
			end else if ((word_done && last_word) || (state == sss_pkg::SSS_WAIT && resume)) begin
				svc <= 1'b0;
			end else if (wr_buf) begin
				svc <= 1'b1;
			end
		end
	end

	// Internal serial clock; idles high and freezes high during a pause
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div <= 8'h00;
			sck_int <= 1'b1;
			sck_o <= 1'b1;
			sck_oe_o <= 1'b0;
		end else if (ce_i) begin
			sck_oe_o <= !ctrl.ext_clk;
			if (state == sss_pkg::SSS_RUN && !ctrl.ext_clk && !inhibit_go) begin
				if (div == 8'(HALF_CYC - 1)) begin
					div <= 8'h00;
					sck_int <= !sck_int;
					sck_o <= !sck_int;
				end else begin
					div <= div + 8'h01;
				end
			end else begin
				div <= 8'h00;
				sck_int <= 1'b1; // R19
				sck_o <= 1'b1; // R19
			end
		end
	end

	// Read mux; unmapped words read as zero
	always_comb begin
		next_dat = 32'h0000_0000;
		if (is_buf(wb_adr_i)) begin
			next_dat[7:0] = shared_buffer_regs[wb_adr_i[4:2]];
		end else begin
			case (reg_idx(wb_adr_i))
				`SSS_IDX_CTRL1: next_dat[4:0] = ctrl;
				`SSS_IDX_CTRL2: next_dat[2:0] = word_count;
				`SSS_IDX_STAT: begin
					next_dat[`SSS_ST_ACTIVE] = transfer_active_flag_o; // R11
					next_dat[`SSS_ST_WAIT] = (state == sss_pkg::SSS_WAIT);
				end
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	// Every request is answered one cycle later, then ack drops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_dat;
			end
		end
	end

	// Helpers that let the checks see where the last byte went
	logic [2:0] idx_d;
	logic [7:0] rx_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_d <= 3'h0;
			rx_d <= 8'h00;
		end else if (ce_i && word_done) begin
			idx_d <= word_idx;
			rx_d <= rx_word;
		end
	end

	chk_rx_to_buffer: assert property (@(posedge clk_i) disable iff (rst_i) // R04
		ce_i && word_done && !inhibit_go && !mode_chg |=> shared_buffer_regs[idx_d] == rx_d)
		else $error("received byte not stored in its buffer word");
	chk_irq_at_count: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		$rose(serial_done_irq_o) |-> $past(word_idx) == $past(word_count) && $past(word_done))
		else $error("completion interrupt at wrong word");
	chk_inhibit_stops: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		ce_i && inhibit_go |=> state == sss_pkg::SSS_IDLE && !transfer_active_flag_o)
		else $error("inhibit did not end the exchange at once");
	chk_stop_after_word: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		ce_i && state == sss_pkg::SSS_RUN && word_done && !ctrl.start && !inhibit_go
		|=> state == sss_pkg::SSS_IDLE ##1 !transfer_active_flag_o)
		else $error("exchange did not stop after the word in progress");
	chk_start_active: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		ce_i && start_go |=> transfer_active_flag_o && state == sss_pkg::SSS_RUN)
		else $error("start did not raise the active flag");
	chk_idle_flag_low: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		state == sss_pkg::SSS_IDLE && $past(state) == sss_pkg::SSS_IDLE |-> !transfer_active_flag_o)
		else $error("active flag high while idle");
	chk_pause_clock: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		state == sss_pkg::SSS_WAIT ##1 state == sss_pkg::SSS_WAIT |-> sck_o && $stable(sck_o))
		else $error("serial clock moved during pause");
	chk_no_pause_serviced: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && state == sss_pkg::SSS_RUN && word_done && last_word && ctrl.start && resume && !inhibit_go
		|=> state == sss_pkg::SSS_RUN) else $error("paused although a word was written");
endmodule

//--- tb/sss_peer.sv
/*
 * Serial partner model: shifts a byte each way per word, LSB first.
 * Assumes it sees the resolved clock line, which idles high.
 */
`timescale 1ns/10ps
module sss_peer (
	// Link wires
	input wire logic sck_i,
	input wire logic so_i,
	output logic si_o,
	output logic sck_o
);
	logic [7:0] snd[$];
	logic [7:0] got[$];
	logic [7:0] tx = 8'hFF;
	logic [7:0] rx = 8'h00;
	int n = 0;
	initial si_o = 1'b1;
	initial sck_o = 1'b1;
	// Next bit out on the falling edge; an empty queue sends all ones
	always @(negedge sck_i) begin
		if (n == 0)
			tx = (snd.size() > 0) ? snd.pop_front() : 8'hFF;
		si_o <= tx[n];
	end
	// Sample on the rising edge; si holds until the next falling edge, as a real far side must
	always @(posedge sck_i) begin
		rx[n] = so_i;
		if (n == 7) begin
			got.push_back(rx);
		end
		n = (n + 1) % 8;
	end
	// External clock, 32 ns period, only inside a frame
	task automatic burst(input int k);
		repeat (k) begin
			sck_o = 1'b0;
			#16;
			sck_o = 1'b1;
			#16;
		end
	endtask
endmodule

//--- tb/sss_top_tb.sv
/*
 * Self-checking bench of the full-duplex serial block.
 * Assumes sss_top and the sss_peer partner on the serial side.
 */
`timescale 1ns/10ps
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", s, e, g); end end
module sss_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [3:0] sel = 4'hF;
	logic ce_i = 1'b1;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, sck_o, sck_oe_o, so_o, si, sck_ext, sck_w, irq, act;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int g0;
	// Released clock line follows the partner's clock, which idles high
	assign sck_w = sck_oe_o ? sck_o : sck_ext;
	always #2 clk_i = ~clk_i;
	sss_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .si_i(si), .so_o(so_o),
		.serial_done_irq_o(irq), .transfer_active_flag_o(act));
	sss_peer peer (.sck_i(sck_w), .so_i(so_o), .si_o(si), .sck_o(sck_ext));
	// Classic single cycle; read data taken at the ack edge
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`CHK("ack", 1'b1, wb_ack_o)
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0);
		`CHK(s, e, q)
	endtask
	// Bounded wait for the done pulse (w 0) or the active flag to drop (w 1)
	task automatic wait_ev(input int w, input int lim);
		int t;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while ((w == 0 ? irq : ~act) !== 1'b1 && t < lim);
	endtask
	task automatic s_reset();
		// The unknown clock line settling high at start-up looks like a rising edge
		peer.n = 0;
		`CHK("sck", 1'b1, sck_o)
		`CHK("oe", 1'b0, sck_oe_o)
		`CHK("so", 1'b1, so_o)
		`CHK("active", 1'b0, act)
		// A write without byte lane 0 is acked but dropped
		sel = 4'hE;
		bus(1'b1, 6'h04, 32'h05);
		sel = 4'hF;
		rd(6'h04, 32'h0, "ctrl2");
		bus(1'b1, 6'h0C, 32'hFF);
		rd(6'h0C, 32'h0, "unmapped");
	endtask
	// One word on the internal clock, then the automatic pause
	task automatic s_one();
		int lows;
		logic [2:0] fz;
		lows = 0;
		bus(1'b1, 6'h00, 32'h0C);
		bus(1'b1, 6'h04, 32'h00);
		bus(1'b1, 6'h20, 32'hA5);
		peer.snd.push_back(8'h3C);
		g0 = peer.got.size();
		bus(1'b1, 6'h00, 32'h0D);
		repeat (3) @(posedge clk_i);
		`CHK("active", 1'b1, act)
		`CHK("oe", 1'b1, sck_oe_o)
		// Clock enable low freezes the running frame
		ce_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		fz = {sck_o, so_o, act};
		repeat (20) @(posedge clk_i);
		`CHK("frozen", fz, {sck_o, so_o, act})
		ce_i <= 1'b1;
		wait_ev(0, 300);
		`CHK("irq", 1'b1, irq)
		`CHK("peer rx", 8'hA5, peer.got[g0])
		rd(6'h20, 32'h3C, "buf0");
		rd(6'h08, 32'h3, "stat");
		repeat (40) begin
			@(posedge clk_i);
			lows += (sck_o !== 1'b1);
		end
		`CHK("sck low", 0, lows)
	endtask
	// Eight words; writes during the batch keep it from pausing; clear start mid-word
	task automatic s_batch();
		bus(1'b1, 6'h04, 32'h07);
		g0 = peer.got.size();
		for (int i = 0; i < 8; i++) begin
			peer.snd.push_back(8'h80 + i[7:0]);
			bus(1'b1, 6'h20 + 6'(4 * i), 32'h10 + i);
		end
		wait_ev(0, 1000);
		`CHK("words", g0 + 8, peer.got.size())
		for (int i = 0; i < 8; i++) begin
			`CHK("peer rx", 8'h10 + i[7:0], peer.got[g0 + i])
			rd(6'h20 + 6'(4 * i), 32'h80 + i, "buf");
		end
		rd(6'h08, 32'h1, "stat");
		g0 = peer.got.size();
		bus(1'b1, 6'h00, 32'h0C);
		wait_ev(1, 200);
		`CHK("active", 1'b0, act)
		`CHK("words", g0 + 1, peer.got.size())
		rd(6'h20, 32'hFF, "last word");
	endtask
	// Inhibit mid-word ends at once and finishes no word
	task automatic s_inhibit();
		bus(1'b1, 6'h00, 32'h0D);
		repeat (30) @(posedge clk_i);
		g0 = peer.got.size();
		bus(1'b1, 6'h00, 32'h0E);
		repeat (2) @(posedge clk_i);
		`CHK("active", 1'b0, act)
		`CHK("sck", 1'b1, sck_o)
		repeat (100) @(posedge clk_i);
		`CHK("words", g0, peer.got.size())
		peer.n = 0;
	endtask
	// Partner clocks the word; stop, then change the count once idle
	task automatic s_ext();
		bus(1'b1, 6'h00, 32'h1C);
		rd(6'h00, 32'h1C, "ctrl1");
		bus(1'b1, 6'h04, 32'h00);
		bus(1'b1, 6'h20, 32'h5A);
		peer.snd.push_back(8'hC3);
		g0 = peer.got.size();
		bus(1'b1, 6'h00, 32'h1D);
		repeat (3) @(posedge clk_i);
		`CHK("oe", 1'b0, sck_oe_o)
		#1;
		fork
			peer.burst(8);
			begin
				wait_ev(0, 200);
				`CHK("irq", 1'b1, irq)
			end
		join
		`CHK("peer rx", 8'h5A, peer.got[g0])
		rd(6'h20, 32'hC3, "buf0");
		bus(1'b1, 6'h00, 32'h1C);
		#1;
		peer.burst(8);
		wait_ev(1, 50);
		`CHK("active", 1'b0, act)
		bus(1'b1, 6'h04, 32'h01);
		rd(6'h04, 32'h1, "ctrl2");
	endtask
	// Leaving full-duplex mode wipes the buffer
	task automatic s_mode();
		bus(1'b1, 6'h24, 32'h55);
		rd(6'h24, 32'h55, "buf1");
		bus(1'b1, 6'h00, 32'h00);
		rd(6'h24, 32'h0, "buf1");
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Ceiling far above the thousand or so cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		s_reset();
		s_one();
		s_batch();
		s_inhibit();
		s_ext();
		s_mode();
		complete_run();
	end
endmodule
